// ### verilog/iuac_comparator.sv
// Function
// - two instances, usable at stages two to four
// - accept IPv4/IPv6 with optional UDP, and ACH
// - UDP expected only after inner IP header
// - IPv4 header length verifies next offset
// - IPv6 header size verifies next offset
// - UDP ports checked against shared setting
// - IPv4 options and fragments unsupported
// - per-flow source/destination/either address match
// - innermost IPv6 keeps valid UDP checksum
// - checksum is one's complement sum check
// - adjust pad bytes when fields change, in IPv6 mode only
// - IPv6 extension headers unsupported
// - ACH accepted after MPLS label stack
// - ACH checked as protocol, no flows
// - IPSec frames: two-step only, no modify
// - one match/mask set detects IPSec header
// - ingress timestamp: reserved bytes or CRC
// - field widths 4,8,32,32/128,64 bits
// - 2-bit mode selects protocol and version check
// - 3-bit following-stage pointer, reserved codes
//
// Implementation choices: the plain strobed port and the placing of the registers.
`include "iuac_map.svh"
`timescale 1ns/1ps
`default_nettype none
module iuac_comparator #(
    parameter logic [2:0] OWN_CODE = 3'h2
) (
    input wire logic CLK,
    input wire logic RST,
    input wire iuac_pkg::iuac_addr_t ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic IN_VALID,
    input wire logic IN_SOF,
    input wire logic IN_EOF,
    input wire logic [7:0] IN_DATA,
    input wire logic [2:0] IN_TARGET,
    input wire logic [2:0] IN_STAGE,
    input wire logic MOD_VALID,
    input wire logic [15:0] MOD_OLD,
    input wire logic [15:0] MOD_NEW,
    output logic OUT_VALID,
    output logic [`IUAC_NFLOW-1:0] OUT_FLOW_MATCH,
    output logic OUT_PROT_OK,
    output logic [7:0] OUT_NEXT_OFFSET,
    output logic [2:0] OUT_NEXT_STAGE,
    output logic OUT_IPSEC,
    output logic OUT_TWO_STEP_ONLY,
    output logic OUT_TS_IN_CRC,
    output logic OUT_CSUM_OK,
    output logic [15:0] OUT_PAD
);
    import iuac_pkg::*;

    iuac_state_s r_reg;
    iuac_state_s r_next;
    // ****************************************
    // byte position and windows
    // ****************************************
    function automatic logic in_win(input logic [7:0] idx, input logic [7:0] start, input logic [7:0] len);
        logic [7:0] d;
        d = idx - start;
        in_win = (idx >= start) && (d < len);
    endfunction

    logic sel;
    logic sof_ok;
    logic byte_ok;
    logic [7:0] idx;
    logic [7:0] fofs;
    logic [255:0] addr_nx;
    logic wide;
    assign sel = (IN_TARGET == OWN_CODE) && (IN_STAGE == r_reg.ctrl[`IUAC_F_STAGE]);
    assign sof_ok = IN_VALID && IN_SOF && sel;
    assign byte_ok = sof_ok || (IN_VALID && !IN_SOF && (r_reg.st == IUAC_ACTIVE));
    assign idx = IN_SOF ? 8'h00 : r_reg.pos;
    assign fofs = {3'b000, r_reg.nxt[`IUAC_F_FOFS]};
    assign addr_nx = (byte_ok && in_win(idx, fofs, wide ? `IUAC_ADDR_BYTES : `IUAC_ADDR4_BYTES))
                     ? {r_reg.addr[247:0], IN_DATA} : r_reg.addr;
    assign wide = (r_reg.ctrl[`IUAC_F_MODE] == `IUAC_MODE_V6) || (r_reg.ctrl[`IUAC_F_MODE] == `IUAC_MODE_W128);

    // ****************************************
    // one's complement arithmetic
    // ****************************************
    logic [15:0] cs_base;
    logic [15:0] cs_word;
    logic [15:0] cs_sum;
    logic [15:0] pad_a;
    logic [15:0] pad_b;
    assign cs_base = IN_SOF ? 16'h0000 : r_reg.csum;
    assign cs_word = idx[0] ? {r_reg.hi, IN_DATA} : {IN_DATA, 8'h00};
    iuac_oc_add u_csum (.a(cs_base), .b(cs_word), .y(cs_sum));
    iuac_oc_add u_pad_a (.a(r_reg.pad), .b(MOD_OLD), .y(pad_a));
    iuac_oc_add u_pad_b (.a(pad_a), .b(~MOD_NEW), .y(pad_b));

    // ****************************************
    // per-flow address match
    // ****************************************
    logic [`IUAC_NFLOW-1:0] fhit;
    genvar g;
    generate
        for (g = 0; g < `IUAC_NFLOW; g = g + 1) begin : g_flow
            logic [127:0] fa;
            logic [127:0] src;
            logic [127:0] dst;
            logic [1:0] fm;
            logic sm;
            logic dm;
            assign fm = r_reg.flow_mode[2*g+1:2*g];
            assign fa = wide ? {r_reg.faddr[4*g], r_reg.faddr[4*g+1], r_reg.faddr[4*g+2], r_reg.faddr[4*g+3]}
                             : {r_reg.faddr[4*g], 96'h0};
            assign src = wide ? addr_nx[255:128] : {addr_nx[63:32], 96'h0};
            assign dst = wide ? addr_nx[127:0] : {addr_nx[31:0], 96'h0};
            assign sm = (src == fa);
            assign dm = (dst == fa);
            assign fhit[g] = ((fm == `IUAC_FM_SRC) && sm) || ((fm == `IUAC_FM_DST) && dm)
                             || ((fm == `IUAC_FM_ANY) && (sm || dm));
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [1:0] mode;
        logic ach;
        logic udp_eff;
        logic esp_exp;
        logic m2hit;
        logic p1ok;
        logic ver_ok;
        logic [7:0] hdr;
        logic [7:0] nofs;
        logic [7:0] udp_pos;
        logic [7:0] o1;
        logic [7:0] o2;
        mode = r_reg.ctrl[`IUAC_F_MODE];
        m2hit = 1'b0;
        p1ok = 1'b0;
        ver_ok = 1'b1;
        ach = r_reg.ctrl[`IUAC_F_ACH];
        udp_eff = r_reg.ctrl[`IUAC_F_UDP] && !r_reg.ctrl[`IUAC_F_OUTER];
        esp_exp = !ach && (|r_reg.k2);
        o1 = {3'b000, r_reg.prot[`IUAC_F_O1]};
        o2 = {1'b0, r_reg.prot[`IUAC_F_O2]};
        hdr = (mode == `IUAC_MODE_V4) ? {2'b00, r_reg.vhl[3:0], 2'b00} : `IUAC_LEN6;
        if (esp_exp) begin
            hdr = hdr + `IUAC_LEN_ESP;
        end
        udp_pos = hdr;
        nofs = udp_eff ? hdr + `IUAC_LEN_UDP : hdr;
        r_next = r_reg;
        r_next.out_valid = 1'b0;
        // ********** register bus **********
        r_next.rdata = `IUAC_RST_ZERO;
        if (WR) begin
            if (ADDR == `IUAC_A_CTRL) begin
                r_next.ctrl[12:5] = WDATA[12:5];
                r_next.ctrl[`IUAC_F_MODE] = WDATA[`IUAC_F_MODE];
                if ((WDATA[`IUAC_F_STAGE] >= `IUAC_STAGE_MIN) && (WDATA[`IUAC_F_STAGE] <= `IUAC_STAGE_MAX)) begin
                    r_next.ctrl[`IUAC_F_STAGE] = WDATA[`IUAC_F_STAGE];
                end else begin
                    r_next.ctrl[`IUAC_F_STAGE] = r_reg.ctrl[`IUAC_F_STAGE];
                end
                // reserved pointer codes are not taken
                if ((WDATA[`IUAC_F_PTR] == `IUAC_PTR_ETH2) || (WDATA[`IUAC_F_PTR] == `IUAC_PTR_IP1)
                    || (WDATA[`IUAC_F_PTR] == `IUAC_PTR_IP2) || (WDATA[`IUAC_F_PTR] == `IUAC_PTR_PTP)) begin
                    r_next.ctrl[`IUAC_F_PTR] = WDATA[`IUAC_F_PTR];
                end
            end else if (ADDR == `IUAC_A_UDP) begin
                r_next.udp_ports = WDATA;
            end else if (ADDR == `IUAC_A_PROT) begin
                r_next.prot = WDATA[27:0];
            end else if (ADDR == `IUAC_A_NXT) begin
                r_next.nxt = WDATA[12:0];
            end else if (ADDR == `IUAC_A_M2LO) begin
                r_next.m2[31:0] = WDATA;
            end else if (ADDR == `IUAC_A_M2HI) begin
                r_next.m2[63:32] = WDATA;
            end else if (ADDR == `IUAC_A_K2LO) begin
                r_next.k2[31:0] = WDATA;
            end else if (ADDR == `IUAC_A_K2HI) begin
                r_next.k2[63:32] = WDATA;
            end else if (ADDR == `IUAC_A_FLOW) begin
                r_next.flow_mode = WDATA[3:0];
            end else if (ADDR[7:5] == `IUAC_A_ADDR_HI) begin
                r_next.faddr[ADDR[4:2]] = WDATA;
            end
        end
        if (RD) begin
            if (ADDR == `IUAC_A_CTRL) begin
                r_next.rdata = {19'h0, r_reg.ctrl};
            end else if (ADDR == `IUAC_A_UDP) begin
                r_next.rdata = r_reg.udp_ports;
            end else if (ADDR == `IUAC_A_PROT) begin
                r_next.rdata = {4'h0, r_reg.prot};
            end else if (ADDR == `IUAC_A_NXT) begin
                r_next.rdata = {19'h0, r_reg.nxt};
            end else if (ADDR == `IUAC_A_M2LO) begin
                r_next.rdata = r_reg.m2[31:0];
            end else if (ADDR == `IUAC_A_M2HI) begin
                r_next.rdata = r_reg.m2[63:32];
            end else if (ADDR == `IUAC_A_K2LO) begin
                r_next.rdata = r_reg.k2[31:0];
            end else if (ADDR == `IUAC_A_K2HI) begin
                r_next.rdata = r_reg.k2[63:32];
            end else if (ADDR == `IUAC_A_FLOW) begin
                r_next.rdata = {28'h0, r_reg.flow_mode};
            end else if (ADDR == `IUAC_A_STAT) begin
                r_next.rdata = {10'h0, (r_reg.st == IUAC_ACTIVE), r_reg.out_match, r_reg.out_csum,
                                r_reg.out_ipsec, r_reg.out_ok, r_reg.pad};
            end else if (ADDR[7:5] == `IUAC_A_ADDR_HI) begin
                r_next.rdata = r_reg.faddr[ADDR[4:2]];
            end
        end
        // ********** header capture **********
        if (MOD_VALID && r_reg.ctrl[`IUAC_F_UPD] && (mode == `IUAC_MODE_V6)) begin
            r_next.pad = pad_b;
        end
        if (byte_ok) begin
            r_next.st = IUAC_ACTIVE;
            r_next.pos = (idx == 8'hFF) ? idx : idx + 8'h01;
            r_next.addr = addr_nx;
            if (!(MOD_VALID && r_reg.ctrl[`IUAC_F_UPD])) begin
                r_next.pad = {r_reg.pad[7:0], IN_DATA};
            end
            if (idx == 8'h00) begin
                r_next.vhl = IN_DATA;
            end
            if (idx == 8'h06) begin
                r_next.frag[15:8] = IN_DATA;
            end
            if (idx == 8'h07) begin
                r_next.frag[7:0] = IN_DATA;
            end
            if (idx == o1) begin
                r_next.cap1 = IN_DATA;
            end
            if (in_win(idx, o2, `IUAC_WIN2_BYTES)) begin
                r_next.win2 = {r_reg.win2[55:0], IN_DATA};
            end
            if (in_win(idx, udp_pos, `IUAC_PORT_BYTES)) begin
                r_next.ports = {r_reg.ports[23:0], IN_DATA};
            end
            if (!idx[0]) begin
                r_next.hi = IN_DATA;
            end
            if (IN_SOF) begin
                r_next.csum = 16'h0000;
            end
            if (idx[0] || IN_EOF) begin
                r_next.csum = cs_sum;
            end
        end
        // ********** frame verdict **********
        m2hit = ((r_next.win2 ^ r_reg.m2) & r_reg.k2) == 64'h0;
        p1ok = ((r_next.cap1 ^ r_reg.prot[`IUAC_F_M1]) & r_reg.prot[`IUAC_F_K1]) == 8'h00;
        if (mode == `IUAC_MODE_V4) begin
            ver_ok = (r_next.vhl[7:4] == `IUAC_VER4) && (r_next.vhl[3:0] == `IUAC_HLEN4)
                     && (r_next.frag[13:0] == 14'h0000);
        end else if (mode == `IUAC_MODE_V6) begin
            ver_ok = (r_next.vhl[7:4] == `IUAC_VER6) && (r_next.cap1 != `IUAC_X_HOP) && (r_next.cap1 != `IUAC_X_ROUTE)
                     && (r_next.cap1 != `IUAC_X_FRAG) && (r_next.cap1 != `IUAC_X_DOPT);
        end else begin
            nofs = r_reg.nxt[`IUAC_F_NOFS];
        end
        if (byte_ok && IN_EOF) begin
            r_next.st = IUAC_IDLE;
            r_next.out_valid = 1'b1;
            r_next.out_ptr = r_reg.ctrl[`IUAC_F_PTR];
            if (ach) begin
                // ach sits where the control word would be and carries no flows
                r_next.out_ok = m2hit;
                r_next.out_nofs = r_reg.nxt[`IUAC_F_NOFS];
                r_next.out_match = 2'b00;
                r_next.out_ipsec = 1'b0;
            end else begin
                r_next.out_ok = ver_ok && p1ok && m2hit && (nofs == r_reg.nxt[`IUAC_F_NOFS])
                                && (!udp_eff || (r_next.ports == r_reg.udp_ports));
                r_next.out_nofs = nofs;
                r_next.out_match = fhit;
                r_next.out_ipsec = esp_exp && m2hit;
            end
            r_next.out_two = !ach && esp_exp && m2hit;
            r_next.out_crc = r_reg.ctrl[`IUAC_F_TSCRC] && !ach && esp_exp && m2hit;
            r_next.out_csum = (mode == `IUAC_MODE_V6) && udp_eff && (r_next.csum == `IUAC_CSUM_GOOD);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            r_reg <= '0;
            r_reg.st <= IUAC_IDLE;
            r_reg.ctrl <= `IUAC_RST_CTRL;
            r_reg.out_ptr <= `IUAC_PTR_PTP;
        end else begin
            r_reg <= r_next;
        end
    end
    assign RDATA = r_reg.rdata;
    assign OUT_VALID = r_reg.out_valid;
    assign OUT_FLOW_MATCH = r_reg.out_match;
    assign OUT_PROT_OK = r_reg.out_ok;
    assign OUT_NEXT_OFFSET = r_reg.out_nofs;
    assign OUT_NEXT_STAGE = r_reg.out_ptr;
    assign OUT_IPSEC = r_reg.out_ipsec;
    assign OUT_TWO_STEP_ONLY = r_reg.out_two;
    assign OUT_TS_IN_CRC = r_reg.out_crc;
    assign OUT_CSUM_OK = r_reg.out_csum;
    assign OUT_PAD = r_reg.pad;
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    property p_ptr_legal;
        (OUT_NEXT_STAGE == `IUAC_PTR_ETH2) || (OUT_NEXT_STAGE == `IUAC_PTR_IP1)
        || (OUT_NEXT_STAGE == `IUAC_PTR_IP2) || (OUT_NEXT_STAGE == `IUAC_PTR_PTP);
    endproperty
    a_ptr_legal: assert property (p_ptr_legal) else $error("reserved next-stage code");
    property p_stage_range;
        (r_reg.ctrl[`IUAC_F_STAGE] >= `IUAC_STAGE_MIN) && (r_reg.ctrl[`IUAC_F_STAGE] <= `IUAC_STAGE_MAX);
    endproperty
    a_stage_range: assert property (p_stage_range) else $error("stage outside two to four");
    property p_eof_verdict;
        byte_ok && IN_EOF |=> OUT_VALID ##1 !OUT_VALID || $past(byte_ok && IN_EOF);
    endproperty
    a_eof_verdict: assert property (p_eof_verdict) else $error("verdict not one cycle after end");
    property p_ipsec_two;
        OUT_VALID && OUT_IPSEC |-> OUT_TWO_STEP_ONLY && !$past(r_reg.ctrl[`IUAC_F_ACH]);
    endproperty
    a_ipsec_two: assert property (p_ipsec_two) else $error("ipsec without two-step");
    property p_ach_noflow;
        OUT_VALID && r_reg.ctrl[`IUAC_F_ACH] && $stable(r_reg.ctrl) |-> OUT_FLOW_MATCH == 2'b00 && !OUT_IPSEC;
    endproperty
    a_ach_noflow: assert property (p_ach_noflow) else $error("ach frame reported a flow");
    property p_flow_off;
        OUT_VALID && $stable(r_reg.flow_mode) |-> (OUT_FLOW_MATCH[0] -> r_reg.flow_mode[1:0] != 2'b00)
            && (OUT_FLOW_MATCH[1] -> r_reg.flow_mode[3:2] != 2'b00);
    endproperty
    a_flow_off: assert property (p_flow_off) else $error("disabled flow matched");
    property p_v4_offset;
        OUT_VALID && OUT_PROT_OK && $stable(r_reg.ctrl) && $stable(r_reg.k2) && (r_reg.k2 == 64'h0)
        && (r_reg.ctrl[`IUAC_F_MODE] == `IUAC_MODE_V4) && !r_reg.ctrl[`IUAC_F_ACH] && !r_reg.ctrl[`IUAC_F_OUTER]
        |-> OUT_NEXT_OFFSET == `IUAC_LEN4 + (r_reg.ctrl[`IUAC_F_UDP] ? `IUAC_LEN_UDP : 8'h00)
        && r_reg.vhl[3:0] == `IUAC_HLEN4;
    endproperty
    a_v4_offset: assert property (p_v4_offset) else $error("ipv4 offset not header plus udp");
    property p_csum_v6;
        OUT_VALID && OUT_CSUM_OK |-> r_reg.csum == `IUAC_CSUM_GOOD && $past(r_reg.ctrl[`IUAC_F_MODE]) == `IUAC_MODE_V6;
    endproperty
    a_csum_v6: assert property (p_csum_v6) else $error("checksum flag without good sum");
    property p_outer_csum;
        OUT_VALID && $past(r_reg.ctrl[`IUAC_F_OUTER]) |-> !OUT_CSUM_OK;
    endproperty
    a_outer_csum: assert property (p_outer_csum) else $error("udp assumed after outer header");
    property p_rd_data;
        RD && (ADDR == `IUAC_A_FLOW) |=> RDATA == {28'h0, $past(r_reg.flow_mode)};
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data late or wrong");

    c_ok: cover property (OUT_VALID && OUT_PROT_OK);
    c_ipsec: cover property (OUT_VALID && OUT_IPSEC);
    c_match: cover property (OUT_VALID && (OUT_FLOW_MATCH != 2'b00));
    c_csum: cover property (OUT_VALID && OUT_CSUM_OK);
endmodule
`default_nettype wire

// ### verilog/iuac_map.svh
`ifndef IUAC_MAP_SVH
`define IUAC_MAP_SVH
// ****************************************
// register byte addresses
// ****************************************
`define IUAC_A_CTRL 8'h00
`define IUAC_A_UDP 8'h04
`define IUAC_A_PROT 8'h08
`define IUAC_A_NXT 8'h0C
`define IUAC_A_M2LO 8'h10
`define IUAC_A_M2HI 8'h14
`define IUAC_A_K2LO 8'h18
`define IUAC_A_K2HI 8'h1C
`define IUAC_A_FLOW 8'h20
`define IUAC_A_STAT 8'h24
`define IUAC_A_ADDR_HI 3'h2
// ****************************************
// field positions
// ****************************************
`define IUAC_F_MODE 1:0
`define IUAC_F_PTR 4:2
`define IUAC_F_UDP 5
`define IUAC_F_OUTER 6
`define IUAC_F_UPD 7
`define IUAC_F_TSCRC 8
`define IUAC_F_STAGE 11:9
`define IUAC_F_ACH 12
`define IUAC_F_M1 7:0
`define IUAC_F_K1 15:8
`define IUAC_F_O1 20:16
`define IUAC_F_O2 27:21
`define IUAC_F_NOFS 7:0
`define IUAC_F_FOFS 12:8
// ****************************************
// reset values
// ****************************************
`define IUAC_RST_CTRL 13'h0414
`define IUAC_RST_ZERO 32'h0000_0000
// ****************************************
// codes and lengths
// ****************************************
`define IUAC_NFLOW 2
`define IUAC_MODE_V4 2'h0
`define IUAC_MODE_V6 2'h1
`define IUAC_MODE_W128 2'h3
`define IUAC_FM_SRC 2'h1
`define IUAC_FM_DST 2'h2
`define IUAC_FM_ANY 2'h3
`define IUAC_PTR_ETH2 3'h1
`define IUAC_PTR_IP1 3'h2
`define IUAC_PTR_IP2 3'h3
`define IUAC_PTR_PTP 3'h5
`define IUAC_STAGE_MIN 3'h2
`define IUAC_STAGE_MAX 3'h4
`define IUAC_VER4 4'h4
`define IUAC_VER6 4'h6
`define IUAC_HLEN4 4'h5
`define IUAC_LEN4 8'h14
`define IUAC_LEN6 8'h28
`define IUAC_LEN_UDP 8'h08
`define IUAC_LEN_ESP 8'h08
`define IUAC_ADDR_BYTES 8'h20
`define IUAC_ADDR4_BYTES 8'h08
`define IUAC_WIN2_BYTES 8'h08
`define IUAC_PORT_BYTES 8'h04
`define IUAC_X_HOP 8'h00
`define IUAC_X_ROUTE 8'h2B
`define IUAC_X_FRAG 8'h2C
`define IUAC_X_DOPT 8'h3C
`define IUAC_CSUM_GOOD 16'hFFFF
`endif

// ### verilog/iuac_pkg.sv
package iuac_pkg;
    typedef enum logic {IUAC_IDLE, IUAC_ACTIVE} iuac_state_e;
    typedef logic [7:0] iuac_addr_t;
    typedef struct packed {
        iuac_state_e st;
        logic [12:0] ctrl;
        logic [31:0] udp_ports;
        logic [27:0] prot;
        logic [12:0] nxt;
        logic [63:0] m2;
        logic [63:0] k2;
        logic [3:0] flow_mode;
        logic [7:0][31:0] faddr;
        logic [7:0] pos;
        logic [7:0] vhl;
        logic [15:0] frag;
        logic [7:0] cap1;
        logic [63:0] win2;
        logic [255:0] addr;
        logic [31:0] ports;
        logic [15:0] csum;
        logic [7:0] hi;
        logic [15:0] pad;
        logic [31:0] rdata;
        logic out_valid;
        logic [1:0] out_match;
        logic out_ok;
        logic [7:0] out_nofs;
        logic [2:0] out_ptr;
        logic out_ipsec;
        logic out_two;
        logic out_csum;
        logic out_crc;
    } iuac_state_s;
endpackage

// ### verilog/iuac_oc_add.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// one's complement 16-bit adder
// ****************************************
module iuac_oc_add (
    input wire logic [15:0] a,
    input wire logic [15:0] b,
    output logic [15:0] y
);
    logic [16:0] s;
    logic [16:0] f;
    assign s = {1'b0, a} + {1'b0, b};
    // end-around carry
    assign f = {1'b0, s[15:0]} + {16'h0000, s[16]};
    assign y = f[15:0];
endmodule
`default_nettype wire

// ### tb/iuac_prev_stage.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// previous stage: hands one header over byte by byte
// ********
module iuac_prev_stage (
    input wire logic CLK,
    output logic IN_VALID,
    output logic IN_SOF,
    output logic IN_EOF,
    output logic [7:0] IN_DATA,
    output logic [2:0] IN_TARGET,
    output logic [2:0] IN_STAGE
);
    logic [7:0] mem [0:63];
    integer seed = 7;
    initial {IN_VALID, IN_SOF, IN_EOF, IN_DATA, IN_TARGET, IN_STAGE} = 17'h0_0000;
    // slow mode stalls between bytes, data line toggles while idle
    task automatic send(input int n, input logic [2:0] tgt, input bit slow);
        for (int i = 0; i < n; i++) begin
            while (slow && $random(seed) % 2) begin
                IN_VALID <= 1'b0;
                IN_DATA <= ~IN_DATA;
                @(posedge CLK);
            end
            IN_VALID <= 1'b1;
            IN_SOF <= i == 0;
            IN_EOF <= i == n - 1;
            IN_DATA <= mem[i];
            IN_TARGET <= tgt;
            IN_STAGE <= 3'h2;
            @(posedge CLK);
        end
        {IN_VALID, IN_EOF} <= 2'b00;
        IN_DATA <= ~IN_DATA;
        @(posedge CLK);
    endtask
endmodule
`default_nettype wire

// ### tb/tb_ip_udp_ach_header_comparator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ip_udp_ach_header_comparator;
    import iuac_pkg::*;
    logic CLK, RST, WR, RD, MOD_VALID, IN_VALID, IN_SOF, IN_EOF, OUT_VALID, OUT_PROT_OK, OUT_IPSEC;
    logic OUT_TWO_STEP_ONLY, OUT_TS_IN_CRC, OUT_CSUM_OK;
    logic rd_d = 1'b0;
    iuac_addr_t ADDR;
    logic [31:0] WDATA, RDATA, ports;
    logic [15:0] MOD_OLD, MOD_NEW, OUT_PAD, exp_pad;
    logic [7:0] IN_DATA, OUT_NEXT_OFFSET;
    logic [2:0] IN_TARGET, IN_STAGE, OUT_NEXT_STAGE;
    logic [1:0] OUT_FLOW_MATCH;
    logic [33:0] got_v;
    logic [31:0] rq[$];
    logic [33:0] vq[$];
    integer seed = 55;
    int fails = 0;
    int checked = 0;
    iuac_prev_stage P (.CLK(CLK), .IN_VALID(IN_VALID), .IN_SOF(IN_SOF), .IN_EOF(IN_EOF), .IN_DATA(IN_DATA),
        .IN_TARGET(IN_TARGET), .IN_STAGE(IN_STAGE));
    iuac_comparator #(.OWN_CODE(3'h2)) DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .IN_VALID(IN_VALID), .IN_SOF(IN_SOF), .IN_EOF(IN_EOF), .IN_DATA(IN_DATA),
        .IN_TARGET(IN_TARGET), .IN_STAGE(IN_STAGE), .MOD_VALID(MOD_VALID), .MOD_OLD(MOD_OLD),
        .MOD_NEW(MOD_NEW), .OUT_VALID(OUT_VALID), .OUT_FLOW_MATCH(OUT_FLOW_MATCH), .OUT_PROT_OK(OUT_PROT_OK),
        .OUT_NEXT_OFFSET(OUT_NEXT_OFFSET), .OUT_NEXT_STAGE(OUT_NEXT_STAGE), .OUT_IPSEC(OUT_IPSEC),
        .OUT_TWO_STEP_ONLY(OUT_TWO_STEP_ONLY), .OUT_TS_IN_CRC(OUT_TS_IN_CRC), .OUT_CSUM_OK(OUT_CSUM_OK),
        .OUT_PAD(OUT_PAD));
    assign got_v = {OUT_FLOW_MATCH, OUT_PROT_OK, OUT_NEXT_OFFSET, OUT_NEXT_STAGE, OUT_IPSEC,
        OUT_TWO_STEP_ONLY, OUT_TS_IN_CRC, OUT_CSUM_OK, OUT_PAD};
    // ********
    // helpers
    // ********
    task automatic chk_r(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED rdata exp %h got %h", e, g);
        end
    endtask
    task automatic chk_v(input logic [33:0] e, input logic [33:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED verdict exp %h got %h", e, g);
        end
    endtask
    task automatic final_report();
        if (vq.size() != 0) fails++;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input iuac_addr_t a, input logic [31:0] d);
        {ADDR, WDATA, WR} <= {a, d, 1'b1};
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rd(input iuac_addr_t a, input logic [31:0] e);
        rq.push_back(e);
        {ADDR, RD} <= {a, 1'b1};
        @(posedge CLK);
        RD <= 1'b0;
        @(posedge CLK);
    endtask
    function automatic logic [15:0] ocs(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = a + b;
        return s[15:0] + 16'(s[16]);
    endfunction
    // ipv6 frame, optionally with a security header ahead of udp
    task automatic v6(input int n, input bit sec);
        logic [15:0] s;
        logic [7:0] b;
        int j;
        s = 16'h0000;
        b = 8'($random(seed));
        for (int i = 0; i < n; i++) P.mem[i] = sec && i >= 40 && i < 48 ? b : 8'($random(seed));
        P.mem[0] = 8'h60;
        P.mem[6] = 8'h11;
        for (int i = 0; i < 4; i++) P.mem[n - 16 + i] = ports[31 - 8 * i -: 8];
        wr(8'h10, {4{b}});
        wr(8'h14, {4{b}});
        wr(8'h18, {32{sec}});
        wr(8'h1C, {32{sec}});
        for (int w = 0; w < 8; w++) begin
            j = 8 + 4 * w;
            wr(8'h40 + 8'(4 * w), {P.mem[j], P.mem[j + 1], P.mem[j + 2], P.mem[j + 3]});
        end
        for (int i = 0; i < n - 2; i += 2) s = ocs(s, {P.mem[i], P.mem[i + 1]});
        exp_pad = ~s;
        {P.mem[n - 2], P.mem[n - 1]} = exp_pad;
        vq.push_back({3'b111, sec ? 8'h38 : 8'h30, sec ? 3'h3 : 3'h5, {3{sec}}, 1'b1, exp_pad});
        P.send(n, 3'h2, sec);
    endtask
    // ********
    // clock, watchdog, result monitor
    // ********
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    initial begin
        repeat (5000) @(posedge CLK);
        fails++;
        final_report();
    end
    always @(posedge CLK) begin
        rd_d <= RD;
        if (rd_d) chk_r(rq.pop_front(), RDATA);
        if (OUT_VALID) chk_v(vq.size() ? vq.pop_front() : 'x, got_v);
    end
    // ********
    // main sequence
    // ********
    initial begin
        {RST, WR, RD, MOD_VALID} = 4'b1000;
        {ADDR, WDATA, MOD_OLD, MOD_NEW} = '0;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        rd(8'h00, 32'h0000_0414);
        rd(8'h80, 32'h0000_0000);
        wr(8'h00, 32'h0000_0E30);
        rd(8'h00, 32'h0000_0434);
        ports = $random(seed);
        wr(8'h04, ports);
        wr(8'h08, 32'h0009_FF11);
        wr(8'h0C, 32'h0000_0C1C);
        wr(8'h20, 32'h0000_0009);
        rd(8'h20, 32'h0000_0009);
        // ipv4: good, long header, more-fragments, bad source, frame for the other comparator
        for (int k = 0; k < 5; k++) begin
            for (int i = 0; i < 32; i++) P.mem[i] = 8'($random(seed));
            P.mem[0] = k == 1 ? 8'h46 : 8'h45;
            {P.mem[6], P.mem[7]} = k == 2 ? 16'h2000 : 16'h0000;
            P.mem[9] = 8'h11;
            {P.mem[20], P.mem[21], P.mem[22], P.mem[23]} = ports;
            wr(8'h40, {P.mem[12], P.mem[13], P.mem[14], P.mem[15]});
            wr(8'h50, {P.mem[16], P.mem[17], P.mem[18], P.mem[19]});
            P.mem[13] ^= {8{k == 3}};
            if (k < 4) vq.push_back({k == 3 ? 2'b10 : 2'b11, k % 3 == 0, k == 1 ? 8'h20 : 8'h1C, 7'h50,
                P.mem[30], P.mem[31]});
            P.send(32, k == 4 ? 3'h3 : 3'h2, k[0]);
        end
        wr(8'h00, 32'h0000_04B5);
        wr(8'h08, 32'h0506_FF11);
        wr(8'h0C, 32'h0000_0830);
        v6(56, 1'b0);
        MOD_OLD <= 16'($random(seed));
        MOD_NEW <= 16'($random(seed));
        MOD_VALID <= 1'b1;
        @(posedge CLK);
        MOD_VALID <= 1'b0;
        exp_pad = ocs(ocs(exp_pad, MOD_OLD), ~MOD_NEW);
        @(posedge CLK);
        rd(8'h24, {11'h000, 5'b11101, exp_pad});
        wr(8'h00, 32'h0000_05AD);
        wr(8'h0C, 32'h0000_0838);
        v6(64, 1'b1);
        wr(8'h00, 32'h0000_1475);
        wr(8'h08, 32'h0000_0000);
        // ach word check: a clean header, then one with a flipped bit
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 8; i++) P.mem[i] = P.mem[40];
            P.mem[3] ^= 8'(k);
            vq.push_back({2'b00, k == 0, 8'h38, 7'h50, P.mem[6], P.mem[7]});
            P.send(8, 3'h2, 1'b0);
        end
        repeat (3) @(posedge CLK);
        final_report();
    end
endmodule
`default_nettype wire
